// ===== verilog/uss_top.sv
// single-wire, smartcard and infrared serial front end with wishbone registers
`include "uss_params.svh"

//////////////////////////////////////////////////////////////
module uss_top
  import uss_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // serial pins
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe_out,
  input wire logic rx_pin_in,
  output logic card_clk_out,
  // infrared transceiver
  output logic ir_tx_out,
  input wire logic ir_rx_in
);
  uss_state_t r, q;
  uss_ir_cfg_t ir_cfg;
  logic card, swm, irm, par_en, tx_on, rx_on, parity_reject_enable_en, sclk_en, half_stop;
  logic line_in, ir_rx_nrz, req, tick_tx, tick_rx, tx_busy, rx_busy, pe_now, line_val;
  logic [15:0] div, div_m1, half_m1, stop_m1;
  logic [7:0] prescaler_value, guard;
  logic [4:0] cpre;
  logic [31:0] wv;

  //////////////////////////////////////////////////////////////
  function automatic logic [31:0] uss_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : uss_merge

  function automatic logic [15:0] uss_stop_len(input logic [1:0] stop, input logic [15:0] d);
    case (stop)
      `USS_STOP_HALF: return d >> 1;
      `USS_STOP_TWO: return d << 1;
      `USS_STOP_ONEHALF: return d + (d >> 1);
      default: return d;
    endcase
  endfunction : uss_stop_len

  function automatic logic [31:0] uss_read(input uss_state_t s, input logic [7:0] adr);
    logic [31:0] v;
    v = '0;
    case (adr)
      `USS_ADR_CR1: v[$bits(s.cr1)-1:0] = s.cr1;
      `USS_ADR_CR2: v[$bits(s.cr2)-1:0] = s.cr2;
      `USS_ADR_CR3: v[$bits(s.cr3)-1:0] = s.cr3;
      `USS_ADR_GTPR: v[$bits(s.gtpr)-1:0] = s.gtpr;
      `USS_ADR_BAUD: v[$bits(s.baud)-1:0] = s.baud;
      `USS_ADR_DATA: v[$bits(s.rx_data)-1:0] = s.rx_data;
      `USS_ADR_STAT: begin
        v[`USS_STAT_TC] = s.tx_done;
        v[`USS_STAT_RXNE] = s.rx_full;
        v[`USS_STAT_PE] = s.par_err;
        v[`USS_STAT_FE] = s.frm_err;
        v[`USS_STAT_BRK] = s.brk;
        v[`USS_STAT_TXBUSY] = (s.tx_st != TX_IDLE);
        v[`USS_STAT_RXBUSY] = (s.rx_st != RX_IDLE);
        v[`USS_STAT_TXPEND] = s.tx_pend;
      end
      default: v = '0;
    endcase
    return v;
  endfunction : uss_read

  //////////////////////////////////////////////////////////////
  assign card = r.cr3[`USS_CR3_CARD];
  assign swm = r.cr3[`USS_CR3_SW];
  assign irm = r.cr3[`USS_CR3_IR];
  assign parity_reject_enable_en = r.cr3[`USS_CR3_PARITY_REJECT_ENABLE];
  assign tx_on = r.cr1[`USS_CR1_TX_ON];
  assign rx_on = r.cr1[`USS_CR1_RX_ON];
  assign par_en = r.cr1[`USS_CR1_PAR_EN];
  assign sclk_en = r.cr2[`USS_CR2_SCLK_EN];
  assign half_stop = (r.cr2[`USS_CR2_STOP] == `USS_STOP_HALF) || (r.cr2[`USS_CR2_STOP] == `USS_STOP_ONEHALF);
  assign div = r.baud;
  assign div_m1 = div - 16'h0001;
  assign half_m1 = (div >> 1) - 16'h0001;
  assign stop_m1 = uss_stop_len(r.cr2[`USS_CR2_STOP], div) - 16'h0001;
  assign prescaler_value = r.gtpr[`USS_GT_PSC];
  assign cpre = r.gtpr[`USS_GT_CPRE];
  assign guard = r.gtpr[`USS_GT_GUARD];
  assign tick_tx = (r.tx_cnt == '0);
  assign tick_rx = (r.rx_cnt == '0);
  assign tx_busy = (r.tx_st != TX_IDLE);
  assign rx_busy = (r.rx_st != RX_IDLE);
  assign req = wb_cyc_in && wb_stb_in && !r.ack;
  assign wv = uss_merge(uss_read(r, wb_adr_in), wb_dat_in, wb_sel_in);
  // receive source: shared wire, decoder or rx pin
  assign line_in = (swm || card) ? r.pin_sync : (irm ? ir_rx_nrz : r.rx_sync);
  assign ir_cfg = '{enable: irm, lowpower: r.cr3[`USS_CR3_IRLP], prescaler_value: prescaler_value, baud_div: div};

  uss_irda u_irda (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .cfg_in(ir_cfg),
    .tx_bit_start_in(r.ir_start),
    .tx_bit_in(r.tx_line),
    .tx_busy_in(tx_busy),
    .rx_busy_in(rx_busy),
    .ir_rx_in(ir_rx_in),
    .ir_tx_out(ir_tx_out),
    .rx_nrz_out(ir_rx_nrz)
  );

  //////////////////////////////////////////////////////////////
  always_comb begin
    q = r;
    pe_now = 1'b0;
    line_val = 1'b1;
    q.ir_start = 1'b0;
    q.ack = req;
    q.rdata = '0;
    q.rx_meta = rx_pin_in;
    q.rx_sync = r.rx_meta;
    q.pin_meta = tx_pin_in;
    q.pin_sync = r.pin_meta;
    q.line_prev = line_in;
    q.tx_on_prev = tx_on;
    // bus writes and reads; hardware sets below win over clears
    if (req && wb_we_in) begin
      case (wb_adr_in)
        `USS_ADR_CR1: q.cr1 = wv[$bits(q.cr1)-1:0];
        `USS_ADR_CR2: q.cr2 = wv[$bits(q.cr2)-1:0];
        `USS_ADR_CR3: q.cr3 = wv[$bits(q.cr3)-1:0];
        `USS_ADR_GTPR: q.gtpr = wv[$bits(q.gtpr)-1:0];
        `USS_ADR_BAUD: q.baud = wv[$bits(q.baud)-1:0];
        `USS_ADR_DATA: begin
          if (tx_on) begin
            q.tx_hold = wv[$bits(q.tx_hold)-1:0];
            q.tx_pend = 1'b1;
            q.tx_done = 1'b0;
          end
        end
        `USS_ADR_STAT: begin
          q.tx_done = r.tx_done && wv[`USS_STAT_TC];
          q.par_err = r.par_err && wv[`USS_STAT_PE];
          q.frm_err = r.frm_err && wv[`USS_STAT_FE];
          q.brk = r.brk && wv[`USS_STAT_BRK];
        end
        default: ;
      endcase
    end else if (req) begin
      q.rdata = uss_read(r, wb_adr_in);
      if (wb_adr_in == `USS_ADR_DATA) begin
        q.rx_full = 1'b0;
      end
    end
    //////////////////////////////////////////////////////////////
    // transmitter
    if (!tick_tx) begin
      q.tx_cnt = r.tx_cnt - 16'h0001;
    end
    case (r.tx_st)
      TX_IDLE: begin
        q.tx_line = 1'b1;
        if (tx_on && !r.tx_on_prev && !card) begin
          q.tx_st = TX_PREAMBLE;
          q.tx_bit = '0;
          q.tx_cnt = div_m1;
        end else if (tx_on && r.tx_pend) begin
          q.tx_shift = r.tx_hold;
          q.tx_par = ^r.tx_hold;
          q.tx_pend = 1'b0;
          q.tx_done = 1'b0;
          q.tx_st = TX_DELAY;
          q.tx_cnt = card ? div_m1 : half_m1;
        end
      end
      TX_PREAMBLE: begin
        if (tick_tx) begin
          q.tx_cnt = div_m1;
          q.tx_bit = r.tx_bit + 4'h1;
          if (r.tx_bit == `USS_IDLE_LAST) begin
            q.tx_st = TX_IDLE;
          end
        end
      end
      TX_DELAY: begin
        if (tick_tx) begin
          q.tx_st = TX_START;
          q.tx_line = 1'b0;
          q.ir_start = 1'b1;
          q.tx_cnt = div_m1;
        end
      end
      TX_START: begin
        if (tick_tx) begin
          q.tx_st = TX_DATA;
          q.tx_bit = '0;
          q.tx_line = r.tx_shift[0];
          q.ir_start = 1'b1;
          q.tx_cnt = div_m1;
        end
      end
      TX_DATA: begin
        if (tick_tx) begin
          q.tx_cnt = div_m1;
          q.ir_start = 1'b1;
          q.tx_shift = r.tx_shift >> 1;
          q.tx_bit = r.tx_bit + 4'h1;
          q.tx_line = r.tx_shift[1];
          if (r.tx_bit[2:0] == `USS_DATA_LAST) begin
            if (par_en) begin
              q.tx_st = TX_PARITY;
              q.tx_line = r.tx_par;
            end else begin
              q.tx_st = TX_STOP;
              q.tx_line = 1'b1;
              q.tx_cnt = stop_m1;
            end
          end
        end
      end
      TX_PARITY: begin
        if (tick_tx) begin
          q.tx_st = TX_STOP;
          q.tx_line = 1'b1;
          q.ir_start = 1'b1;
          q.tx_cnt = stop_m1;
        end
      end
      TX_STOP: begin
        if (tick_tx) begin
          if (r.tx_pend && tx_on) begin
            q.tx_st = TX_IDLE;
          end else if (card) begin
            q.tx_st = TX_GUARD;
            q.guard_cnt = '0;
            q.tx_cnt = div_m1;
          end else begin
            q.tx_st = TX_IDLE;
            q.tx_done = 1'b1;
          end
        end
      end
      TX_GUARD: begin
        if (r.tx_pend && tx_on) begin
          q.tx_st = TX_IDLE;
        end else if (r.guard_cnt == guard) begin
          q.tx_done = 1'b1;
          q.tx_st = TX_IDLE;
        end else if (tick_tx) begin
          q.guard_cnt = r.guard_cnt + 8'h01;
          q.tx_cnt = div_m1;
        end
      end
      default: q.tx_st = TX_IDLE;
    endcase
    //////////////////////////////////////////////////////////////
    // receiver
    if (!tick_rx) begin
      q.rx_cnt = r.rx_cnt - 16'h0001;
    end
    case (r.rx_st)
      RX_IDLE: begin
        if (rx_on && r.line_prev && !line_in) begin
          q.rx_st = RX_START;
          q.rx_cnt = half_m1;
        end
      end
      RX_START: begin
        if (tick_rx) begin
          q.rx_st = line_in ? RX_IDLE : RX_DATA;
          q.rx_bit = '0;
          q.rx_cnt = div_m1;
        end
      end
      RX_DATA: begin
        if (tick_rx) begin
          q.rx_shift = {line_in, r.rx_shift[7:1]};
          q.rx_bit = r.rx_bit + 3'h1;
          q.rx_cnt = div_m1;
          if (r.rx_bit == `USS_DATA_LAST) begin
            q.rx_st = par_en ? RX_PARITY : RX_STOP;
          end
        end
      end
      RX_PARITY: begin
        if (tick_rx) begin
          q.rx_par = line_in;
          q.rx_st = RX_STOP;
          q.rx_cnt = div_m1;
        end
      end
      RX_STOP: begin
        if (tick_rx) begin
          pe_now = par_en && ((^r.rx_shift) != r.rx_par);
          q.rx_data = r.rx_shift;
          q.rx_full = 1'b1;
          if (pe_now) begin
            q.par_err = 1'b1;
          end
          if (!line_in) begin
            q.frm_err = 1'b1;
            if (r.rx_shift == '0 && !card) begin
              q.brk = 1'b1;
            end
          end
          if (pe_now && card && parity_reject_enable_en && half_stop) begin
            q.rx_st = RX_PARITY_REJECT_ENABLE_WAIT;
            q.rx_cnt = half_m1;
          end else begin
            q.rx_st = RX_WAIT_HIGH;
          end
        end
      end
      RX_PARITY_REJECT_ENABLE_WAIT: begin
        if (tick_rx) begin
          q.rx_st = RX_PARITY_REJECT_ENABLE;
          q.rx_cnt = div_m1;
        end
      end
      RX_PARITY_REJECT_ENABLE: begin
        if (tick_rx) begin
          q.rx_st = RX_WAIT_HIGH;
        end
      end
      RX_WAIT_HIGH: begin
        if (line_in) begin
          q.rx_st = RX_IDLE;
        end
      end
      default: q.rx_st = RX_IDLE;
    endcase
    //////////////////////////////////////////////////////////////
    // pin drive: open drain for card, released when idle on single wire
    line_val = q.tx_line && (q.rx_st != RX_PARITY_REJECT_ENABLE);
    if (card) begin
      q.pin_out = 1'b0;
      q.pin_oe = !line_val;
    end else if (swm) begin
      q.pin_out = line_val;
      q.pin_oe = (q.tx_st != TX_IDLE);
    end else begin
      q.pin_out = line_val;
      q.pin_oe = 1'b1;
    end
    // card clock toggles every cpre cycles
    if (card && sclk_en && cpre != '0) begin
      if (r.cdiv >= cpre - 5'h01) begin
        q.cdiv = '0;
        q.card_clk = !r.card_clk;
      end else begin
        q.cdiv = r.cdiv + 5'h01;
      end
    end else begin
      q.cdiv = '0;
      q.card_clk = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      r <= '0;
      r.baud <= `USS_BAUD_RST;
    end else if (ce_in) begin
      r <= q;
    end
  end

  //////////////////////////////////////////////////////////////
  assign wb_dat_out = r.rdata;
  assign wb_ack_out = r.ack;
  assign tx_pin_out = r.pin_out;
  assign tx_pin_oe_out = r.pin_oe;
  assign card_clk_out = r.card_clk;
endmodule : uss_top

// ===== verilog/uss_params.svh
// constants for the single-wire, card and infrared serial front end
`ifndef USS_PARAMS_SVH
`define USS_PARAMS_SVH
`define USS_CLK_HZ 25000000
`define USS_IR_MAX_BPS 115200
`define USS_IR_MIN_DIV ((`USS_CLK_HZ + `USS_IR_MAX_BPS - 1) / `USS_IR_MAX_BPS)
`define USS_ADR_CR1 8'h00
`define USS_ADR_CR2 8'h04
`define USS_ADR_CR3 8'h08
`define USS_ADR_GTPR 8'h0c
`define USS_ADR_BAUD 8'h10
`define USS_ADR_DATA 8'h14
`define USS_ADR_STAT 8'h18
`define USS_CR1_TX_ON 0
`define USS_CR1_RX_ON 1
`define USS_CR1_PAR_EN 2
`define USS_CR2_STOP 1:0
`define USS_CR2_SCLK_EN 2
`define USS_CR3_SW 0
`define USS_CR3_CARD 1
`define USS_CR3_IR 2
`define USS_CR3_PARITY_REJECT_ENABLE 3
`define USS_CR3_IRLP 4
`define USS_GT_PSC 7:0
`define USS_GT_CPRE 4:0
`define USS_GT_GUARD 15:8
`define USS_STAT_TC 0
`define USS_STAT_RXNE 1
`define USS_STAT_PE 2
`define USS_STAT_FE 3
`define USS_STAT_BRK 4
`define USS_STAT_TXBUSY 5
`define USS_STAT_RXBUSY 6
`define USS_STAT_TXPEND 7
`define USS_STOP_HALF 2'h1
`define USS_STOP_TWO 2'h2
`define USS_STOP_ONEHALF 2'h3
`define USS_BAUD_RST 16'h00d9
`define USS_DATA_LAST 3'h7
`define USS_IDLE_LAST 4'h9
`define USS_IR_MUL 3
`define USS_IR_SH 4
`define USS_IR_LP_MUL 3
`endif

// ===== verilog/uss_pkg.sv
// types for the single-wire, card and infrared serial front end
package uss_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_PREAMBLE, TX_DELAY, TX_START, TX_DATA, TX_PARITY, TX_STOP,
                            TX_GUARD} uss_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_PARITY_REJECT_ENABLE_WAIT, RX_PARITY_REJECT_ENABLE,
                            RX_WAIT_HIGH} uss_rx_state_t;
  typedef struct packed {
    logic enable;
    logic lowpower;
    logic [7:0] prescaler_value;
    logic [15:0] baud_div;
  } uss_ir_cfg_t;
  typedef struct packed {
    logic meta;
    logic sync;
    logic ir_tx;
    logic nrz;
    logic [15:0] pulse_cnt;
    logic [15:0] low_cnt;
    logic [15:0] hold_cnt;
  } uss_ir_state_t;
  typedef struct packed {
    logic [2:0] cr1;
    logic [2:0] cr2;
    logic [4:0] cr3;
    logic [15:0] gtpr;
    logic [15:0] baud;
    logic rx_meta;
    logic rx_sync;
    logic pin_meta;
    logic pin_sync;
    logic line_prev;
    uss_tx_state_t tx_st;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_par;
    logic [7:0] tx_hold;
    logic tx_pend;
    logic tx_done;
    logic tx_on_prev;
    logic [7:0] guard_cnt;
    logic tx_line;
    logic ir_start;
    uss_rx_state_t rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_par;
    logic [7:0] rx_data;
    logic rx_full;
    logic par_err;
    logic frm_err;
    logic brk;
    logic [4:0] cdiv;
    logic card_clk;
    logic pin_out;
    logic pin_oe;
    logic ack;
    logic [31:0] rdata;
  } uss_state_t;
endpackage : uss_pkg

// ===== verilog/uss_irda.sv
// infrared pulse encoder and glitch-filtered decoder
`include "uss_params.svh"

module uss_irda
  import uss_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // configuration and serial stream
  input wire uss_ir_cfg_t cfg_in,
  input wire logic tx_bit_start_in,
  input wire logic tx_bit_in,
  input wire logic tx_busy_in,
  input wire logic rx_busy_in,
  // infrared pins and decoded stream
  input wire logic ir_rx_in,
  output logic ir_tx_out,
  output logic rx_nrz_out
);
  uss_ir_state_t r, q;
  logic active;
  logic [17:0] norm_w;
  logic [15:0] width_m1, thr, hold_len;

  assign active = cfg_in.enable && (cfg_in.prescaler_value != '0) && (cfg_in.baud_div >= 16'(`USS_IR_MIN_DIV));
  assign norm_w = 18'(({2'h0, cfg_in.baud_div} * `USS_IR_MUL) >> `USS_IR_SH);
  assign width_m1 = (cfg_in.lowpower ? 16'(cfg_in.prescaler_value * `USS_IR_LP_MUL) : norm_w[15:0]) - 16'h0001;
  assign thr = 16'({cfg_in.prescaler_value, 1'b0});
  assign hold_len = cfg_in.baud_div - (cfg_in.baud_div >> 2);

  //////////////////////////////////////////////////////////////
  always_comb begin
    q = r;
    q.meta = ir_rx_in;
    q.sync = r.meta;
    if (!active) begin
      q.ir_tx = 1'b0;
      q.nrz = 1'b1;
      q.low_cnt = '0;
      q.pulse_cnt = '0;
      q.hold_cnt = '0;
    end else begin
      // zero bits pulse high, ones stay low, nothing while receiving
      if (tx_bit_start_in && !tx_bit_in && !rx_busy_in) begin
        q.ir_tx = 1'b1;
        q.pulse_cnt = width_m1;
      end else if (r.pulse_cnt != '0) begin
        q.pulse_cnt = r.pulse_cnt - 16'h0001;
      end else begin
        q.ir_tx = 1'b0;
      end
      // low pulse must last two prescaler periods to count
      if (tx_busy_in) begin
        q.low_cnt = '0;
        q.nrz = 1'b1;
      end else begin
        if (r.sync) begin
          q.low_cnt = '0;
        end else if (r.low_cnt != thr) begin
          q.low_cnt = r.low_cnt + 16'h0001;
        end
        if (!r.sync && (r.low_cnt + 16'h0001 == thr)) begin
          q.nrz = 1'b0;
          q.hold_cnt = hold_len;
        end else if (!r.nrz) begin
          if (r.hold_cnt == '0) begin
            q.nrz = 1'b1;
          end else begin
            q.hold_cnt = r.hold_cnt - 16'h0001;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      r <= '0;
      r.nrz <= 1'b1;
    end else if (ce_in) begin
      r <= q;
    end
  end

  assign ir_tx_out = r.ir_tx;
  assign rx_nrz_out = r.nrz;
endmodule : uss_irda

// ===== tb/uss_peer_model.sv
// shared-wire peer and infrared transceiver model
module uss_peer_model (
  // clock and device pins
  input wire logic clk_in,
  input wire logic pin_in,
  input wire logic oe_in,
  // resolved wire and infrared light
  output logic wire_out,
  output logic ir_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pull_low = 1'b0;
  initial ir_out = 1'b1;
  // pull-up wins when nobody drives
  assign wire_out = (oe_in ? pin_in : 1'b1) & !pull_low;
  //////////////////////////////////////////////////////////////
  task automatic hold(input logic v, input int n);
    pull_low <= !v;
    repeat (n) @(posedge clk_in);
  endtask : hold
  task automatic send(input logic [7:0] b, input logic bad_par, input logic stop_v, input int d);
    hold(1'b0, d);
    for (int i = 0; i < 8; i++) hold(b[i], d);
    hold(^b ^ bad_par, d);
    hold(stop_v, 2 * d);
    hold(1'b1, d);
  endtask : send
  // reject pulse of one or two bit times
  task automatic parity_reject_enable(input int d, input int bits);
    hold(1'b0, bits * d);
    hold(1'b1, 1);
  endtask : parity_reject_enable
  task automatic ir_send(input logic [7:0] b, input int d, input int w);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      ir_out <= f[i];
      repeat (w) @(posedge clk_in);
      ir_out <= 1'b1;
      repeat (d - w) @(posedge clk_in);
    end
  endtask : ir_send
endmodule : uss_peer_model

// ===== tb/uss_top_checker.sv
// port assertions for the serial front end
`include "uss_params.svh"

module uss_top_checker
  import uss_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // bus
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // pins
  input wire logic tx_pin_out,
  input wire logic card_clk_out,
  input wire logic ir_tx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  logic [4:0] cr3_reg;
  logic [15:0] gt_reg;
  logic [15:0] baud_reg;
  logic [17:0] hi_reg;
  logic [4:0] ck_reg;
  logic wr;
  logic [17:0] exp_w;
  assign wr = wb_ack_out && wb_we_in && wb_cyc_in && wb_stb_in;
  assign exp_w = cr3_reg[4] ? 18'(gt_reg[7:0]) * 18'h3 : (18'(baud_reg) * 18'h3) >> 4;
  // shadow of configuration seen on the bus, plus high-time counters of ir_tx_out and card_clk_out
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cr3_reg <= 5'h00;
      gt_reg <= 16'h0000;
      baud_reg <= 16'h00d9;
      hi_reg <= 18'h00000;
      ck_reg <= 5'h00;
    end else begin
      if (wr && wb_adr_in == `USS_ADR_CR3) cr3_reg <= wb_dat_in[4:0];
      if (wr && wb_adr_in == `USS_ADR_GTPR) gt_reg <= wb_dat_in[15:0];
      if (wr && wb_adr_in == `USS_ADR_BAUD) baud_reg <= wb_dat_in[15:0];
      hi_reg <= ir_tx_out ? hi_reg + 18'h00001 : 18'h00000;
      ck_reg <= card_clk_out ? ck_reg + 5'h01 : 5'h00;
    end
  end
  //////////////////////////////////////////////////////////////
  sequence req_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in;
  endsequence
  sequence pulse_s;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  bus_answer_a: assert property (req_s |=> pulse_s) else $error("ack missing or too long");
  read_quiet_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("read data outside ack");
  ir_width_a: assert property ($fell(ir_tx_out) |-> hi_reg == exp_w)
    else $error("infrared pulse width wrong");
  ir_off_a: assert property (gt_reg[7:0] == 8'h00 || !cr3_reg[2] |-> !$rose(ir_tx_out))
    else $error("infrared pulse while encoder off");
  ir_rate_a: assert property (baud_reg < 16'h00da |-> !$rose(ir_tx_out))
    else $error("infrared pulse above rate limit");
  card_clk_gate_a: assert property ($rose(card_clk_out) |-> cr3_reg[1] && gt_reg[4:0] != 5'h00)
    else $error("card clock outside card mode");
  card_clk_high_a: assert property ($fell(card_clk_out) && cr3_reg[1] |-> ck_reg == gt_reg[4:0])
    else $error("card clock half period wrong");
  card_drain_a: assert property (cr3_reg[1] && $past(cr3_reg[1]) |-> !tx_pin_out)
    else $error("card line driven high");
endmodule : uss_top_checker

bind uss_top uss_top_checker u_chk (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .ce_in(ce_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .tx_pin_out(tx_pin_out),
  .card_clk_out(card_clk_out), .ir_tx_out(ir_tx_out));

// ===== tb/tb_top.sv
// register-level tests of the serial front end
`include "uss_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, got;
  logic ack, line, pin, oe, cclk, ir_tx, ir_rx;
  int n_errors = 0;
  int checks_done = 0;
  int lo_n = 0;
  int ir_n = 0;
  int ck_n = 0;
  int n, base;
  always #20 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    lo_n <= lo_n + int'(line === 1'b0);
    ir_n <= ir_n + int'(ir_tx === 1'b1);
    ck_n <= ck_n + int'(cclk === 1'b1);
  end
  uss_top dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .tx_pin_in(line), .tx_pin_out(pin), .tx_pin_oe_out(oe), .rx_pin_in(1'b0), .card_clk_out(cclk),
    .ir_tx_out(ir_tx), .ir_rx_in(ir_rx));
  uss_peer_model u_peer (.clk_in(sys_clk_in), .pin_in(pin), .oe_in(oe), .wire_out(line), .ir_out(ir_rx));
  //////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge sys_clk_in); while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk_in);
  endtask : wb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(got & m, e);
  endtask : rchk
  task automatic until_low();
    n = 0;
    while (line !== 1'b0 && n < 5000) begin
      @(posedge sys_clk_in);
      n++;
    end
  endtask : until_low
  task automatic ir_case(input logic [31:0] c3, input logic [31:0] gt, input logic [31:0] bd, input int e);
    wb(1'b1, `USS_ADR_CR1, 32'h0);
    wb(1'b1, `USS_ADR_CR3, c3);
    wb(1'b1, `USS_ADR_CR2, 32'h0);
    wb(1'b1, `USS_ADR_GTPR, gt);
    wb(1'b1, `USS_ADR_BAUD, bd);
    wb(1'b1, `USS_ADR_CR1, 32'h1);
    repeat (11 * 218) @(posedge sys_clk_in);
    base = ir_n;
    wb(1'b1, `USS_ADR_DATA, 32'h5a);
    repeat (12 * 218) @(posedge sys_clk_in);
    chk(ir_n - base, e);
  endtask : ir_case
  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    rchk(`USS_ADR_BAUD, 32'hffff, 32'hd9);
    rchk(8'h1c, 32'hffffffff, 32'h0);
    // single wire, receive pin held low
    wb(1'b1, `USS_ADR_BAUD, 32'h10);
    wb(1'b1, `USS_ADR_CR3, 32'h1);
    wb(1'b1, `USS_ADR_CR1, 32'h3);
    repeat (192) @(posedge sys_clk_in);
    chk(32'(oe), 32'h0);
    u_peer.send(8'hb5, 1'b0, 1'b1, 16);
    rchk(`USS_ADR_DATA, 32'hff, 32'hb5);
    wb(1'b1, `USS_ADR_DATA, 32'h3c);
    repeat (16) @(posedge sys_clk_in);
    chk(32'(oe), 32'h1);
    repeat (192) @(posedge sys_clk_in);
    // card mode
    wb(1'b1, `USS_ADR_CR1, 32'h0);
    wb(1'b1, `USS_ADR_CR3, 32'ha);
    wb(1'b1, `USS_ADR_CR2, 32'h7);
    wb(1'b1, `USS_ADR_GTPR, 32'h0203);
    base = lo_n;
    wb(1'b1, `USS_ADR_CR1, 32'h7);
    rchk(`USS_ADR_STAT, 32'h20, 32'h0);
    repeat (192) @(posedge sys_clk_in);
    chk(lo_n - base, 0);
    base = ck_n;
    repeat (60) @(posedge sys_clk_in);
    chk(ck_n - base, 30);
    wb(1'b1, `USS_ADR_DATA, 32'h5a);
    until_low();
    chk(32'(n > 12 && n < 20), 32'h1);
    repeat (190) @(posedge sys_clk_in);
    rchk(`USS_ADR_STAT, 32'h1, 32'h0);
    repeat (40) @(posedge sys_clk_in);
    rchk(`USS_ADR_STAT, 32'h1, 32'h1);
    wb(1'b1, `USS_ADR_STAT, 32'h0);
    wb(1'b1, `USS_ADR_DATA, 32'h5a);
    until_low();
    repeat (160) @(posedge sys_clk_in);
    u_peer.parity_reject_enable(16, 2);
    repeat (32) @(posedge sys_clk_in);
    rchk(`USS_ADR_STAT, 32'h48, 32'h8);
    rchk(`USS_ADR_DATA, 32'hff, 32'h5a);
    for (int k = 1; k >= 0; k--) begin
      wb(1'b1, `USS_ADR_CR3, {28'h0, k[0], 3'h2});
      wb(1'b1, `USS_ADR_STAT, 32'h0);
      base = lo_n;
      u_peer.send(8'h33, 1'b1, 1'b1, 16);
      chk(lo_n - base, 80 + 16 * k);
      rchk(`USS_ADR_STAT, 32'h44, 32'h4);
      rchk(`USS_ADR_DATA, 32'hff, 32'h33);
    end
    wb(1'b1, `USS_ADR_STAT, 32'h0);
    u_peer.send(8'h00, 1'b0, 1'b0, 16);
    rchk(`USS_ADR_STAT, 32'h18, 32'h08);
    rchk(`USS_ADR_DATA, 32'hff, 32'h00);
    // infrared transmit cases
    ir_case(32'h04, 32'h0001, 32'hda, 200);
    ir_case(32'h14, 32'h0004, 32'hda, 60);
    ir_case(32'h04, 32'h0000, 32'hda, 0);
    ir_case(32'h04, 32'h0001, 32'hd9, 0);
    // infrared receive through the glitch filter
    wb(1'b1, `USS_ADR_CR1, 32'h0);
    wb(1'b1, `USS_ADR_GTPR, 32'h0004);
    wb(1'b1, `USS_ADR_BAUD, 32'hda);
    wb(1'b1, `USS_ADR_CR1, 32'h2);
    wb(1'b0, `USS_ADR_DATA, 32'h0);
    u_peer.ir_send(8'h00, 218, 3);
    rchk(`USS_ADR_STAT, 32'h2, 32'h0);
    u_peer.ir_send(8'h55, 218, 12);
    rchk(`USS_ADR_DATA, 32'hff, 32'h55);
    give_verdict();
  end
endmodule : tb_top
